// [hw/asr_pkg.sv]
package asr_pkg;

  // Register offsets of the bank.
  localparam logic [5:0] ADDR_ACCEL_X   = 6'h06;
  localparam logic [5:0] ADDR_ACCEL_Y   = 6'h07;
  localparam logic [5:0] ADDR_ACCEL_Z   = 6'h08;
  localparam logic [5:0] ADDR_STATUS    = 6'h09;
  localparam logic [5:0] ADDR_DETECT    = 6'h0a;
  localparam logic [5:0] ADDR_SLAVE     = 6'h0d;
  localparam logic [5:0] ADDR_USER      = 6'h0e;
  localparam logic [5:0] ADDR_SIGNATURE = 6'h0f;
  localparam logic [5:0] ADDR_TRIM_BASE = 6'h10;
  localparam logic [5:0] ADDR_TRIM_X_HI = 6'h11;
  localparam logic [5:0] ADDR_TRIM_Y_LO = 6'h12;
  localparam logic [5:0] ADDR_TRIM_Y_HI = 6'h13;
  localparam logic [5:0] ADDR_TRIM_Z_LO = 6'h14;
  localparam logic [5:0] ADDR_TRIM_LAST = 6'h15;
  localparam logic [5:0] ADDR_IRQ_CLEAR = 6'h17;

  // Status register fields.
  localparam int STAT_READY_BIT  = 0;
  localparam int STAT_OVR_BIT    = 1;
  localparam int STAT_PARITY_BIT = 2;

  // Detection source register fields.
  localparam int DET_IRQ1_BIT    = 0;
  localparam int DET_IRQ2_BIT    = 1;
  localparam int DET_PULSE_LSB   = 2;
  localparam int DET_LEVEL_LSB   = 5;

  // Interrupt latch clear fields.
  localparam int CLR_IRQ1_BIT    = 0;
  localparam int CLR_IRQ2_BIT    = 1;

  // Slave address register fields and reset values.
  localparam int         SLAVE_OFF_BIT    = 7;
  localparam logic [6:0] SLAVE_ADDR_RESET = 7'h1d;
  localparam logic       SLAVE_OFF_RESET  = 1'h0;

  // Offset trim layout.
  localparam int          TRIM_W        = 11;
  localparam int          TRIM_HIGH_W   = 3;
  localparam logic [10:0] TRIM_RESET    = 11'h000;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam logic [7:0]  AXIS_MAX      = 8'h7f;
  localparam logic [7:0]  AXIS_MIN      = 8'h80;

  // Interrupt source selection codes.
  typedef enum logic [1:0] {
    ASR_SEL_LEVEL_PULSE = 2'b00,
    ASR_SEL_PULSE_LEVEL = 2'b01,
    ASR_SEL_SINGLE_ANY  = 2'b10,
    ASR_SEL_UNUSED      = 2'b11
  } asr_irq_sel_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } asr_bus_req_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] z;
  } asr_sample_s;

  typedef struct packed {
    logic [2:0] level_hit;
    logic [2:0] pulse_hit;
    logic       double_pulse;
  } asr_detect_s;

endpackage

// [hw/asr_regs.sv]
`timescale 1ns/1ps
// Summary of operation
// - Axis bytes read signed, zero at rest.
// - Status bit 0 flags fresh sample.
// - Status bit 1 flags overwritten unread sample.
// - Status bit 2 trim parity; blocks self-test.
// - Detect bits 7..5 latch level hits.
// - Detect bits 4..2 latch single pulses.
// - Detect bits 0,1 follow source selection.
// - Address bits fixed 0x1d; bit 7 writable.
// - Bit 7 set disables only two-wire port.
// - User byte comes from one-time storage.
// - Signature byte loaded once, never writable.
// - Eleven-bit trims split low/high, reset zero.
// - Trim bit 0 weighs half count.
// - Trim removes zero offset from outputs.
// - Ready drives first pin when unmasked.
// - Clear bit drops flag and its hits.
module asr_regs (
  input  wire logic                  sys_clk_i,
  input  wire logic                  srst_i,
  input  wire logic                  ce_i,
  input  wire asr_pkg::asr_bus_req_s bus_req_i,
  input  wire asr_pkg::asr_sample_s  sample_i,
  input  wire asr_pkg::asr_detect_s  detect_i,
  input  wire logic [1:0]            irq_source_select_i,
  input  wire logic                  ready_pin_mask_i,
  input  wire logic                  trim_parity_err_i,
  input  wire logic                  otp_valid_i,
  input  wire logic [7:0]            otp_user_info_i,
  input  wire logic [7:0]            otp_signature_i,
  output logic [7:0]                 rd_data_o,
  output logic                       rd_valid_o,
  output logic                       irq_first_pin_o,
  output logic                       irq_second_pin_o,
  output logic                       two_wire_port_en_o,
  output logic                       four_wire_port_en_o,
  output logic                       self_test_allow_o
);

  // Trim value with one fractional bit, sign-extended to leave headroom.
  function automatic logic [7:0] trim_apply(input logic [7:0]  raw,
                                            input logic [10:0] trim);
    logic signed [12:0] sum;
    logic signed [11:0] whole;
    sum   = $signed({{4{raw[7]}}, raw, 1'b0}) + $signed({{2{trim[10]}}, trim});
    whole = sum[12:1];
    if (whole > $signed({4'h0, asr_pkg::AXIS_MAX})) begin
      trim_apply = asr_pkg::AXIS_MAX;
    end else if (whole < $signed({4'hf, asr_pkg::AXIS_MIN})) begin
      trim_apply = asr_pkg::AXIS_MIN;
    end else begin
      trim_apply = whole[7:0];
    end
  endfunction

  function automatic logic is_read(input asr_pkg::asr_bus_req_s req,
                                   input logic [5:0] addr);
    is_read = req.rd && (req.addr == addr);
  endfunction

  logic [7:0]  axis_q [3];
  logic [10:0] trim_q [3];
  logic        ready_q;
  logic        ovr_q;
  logic        parity_q;
  logic [2:0]  level_q;
  logic [2:0]  pulse_q;
  logic        irq1_q;
  logic        irq2_q;
  logic        port_off_q;
  logic [7:0]  user_q;
  logic [7:0]  signature_q;
  logic        otp_loaded_q;

  logic        axis_read;
  logic        clr1;
  logic        clr2;
  logic        level_any;
  logic        pulse_single;
  logic        pulse_any;
  logic        irq1_evt;
  logic        irq2_evt;
  logic        clr1_level;
  logic        clr1_pulse;
  logic        clr2_level;
  logic        clr2_pulse;
  logic [7:0]  det_byte;
  logic [7:0]  rd_data_d;
  asr_pkg::asr_irq_sel_e sel;

  assign sel          = asr_pkg::asr_irq_sel_e'(irq_source_select_i);
  assign axis_read    = is_read(bus_req_i, asr_pkg::ADDR_ACCEL_X) ||
                        is_read(bus_req_i, asr_pkg::ADDR_ACCEL_Y) ||
                        is_read(bus_req_i, asr_pkg::ADDR_ACCEL_Z);
  assign clr1 = bus_req_i.wr && (bus_req_i.addr == asr_pkg::ADDR_IRQ_CLEAR) &&
                bus_req_i.wdata[asr_pkg::CLR_IRQ1_BIT];
  assign clr2 = bus_req_i.wr && (bus_req_i.addr == asr_pkg::ADDR_IRQ_CLEAR) &&
                bus_req_i.wdata[asr_pkg::CLR_IRQ2_BIT];
  assign level_any    = |detect_i.level_hit;
  assign pulse_single = |detect_i.pulse_hit;
  assign pulse_any    = pulse_single || detect_i.double_pulse;

  // Event routing onto the two interrupt flags.
  always_comb begin
    irq1_evt   = 1'b0;
    irq2_evt   = 1'b0;
    clr1_level = 1'b0;
    clr1_pulse = 1'b0;
    clr2_level = 1'b0;
    clr2_pulse = 1'b0;
    case (sel)
      asr_pkg::ASR_SEL_LEVEL_PULSE: begin
        irq1_evt   = level_any;
        irq2_evt   = pulse_any;
        clr1_level = clr1;
        clr2_pulse = clr2;
      end
      asr_pkg::ASR_SEL_PULSE_LEVEL: begin
        irq1_evt   = pulse_any;
        irq2_evt   = level_any;
        clr1_pulse = clr1;
        clr2_level = clr2;
      end
      asr_pkg::ASR_SEL_SINGLE_ANY: begin
        irq1_evt   = pulse_single;
        irq2_evt   = pulse_any;
        clr1_pulse = clr1;
        clr2_pulse = clr2;
      end
      default: begin
        irq1_evt   = 1'b0;
        irq2_evt   = 1'b0;
      end
    endcase
  end

  // Corrected axis bytes; zero acceleration with zero trim reads as zero.
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_axis
      logic [7:0] raw;
      if (g == 0) begin : g_x
        assign raw = sample_i.x;
      end else if (g == 1) begin : g_y
        assign raw = sample_i.y;
      end else begin : g_z
        assign raw = sample_i.z;
      end
      always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
          axis_q[g] <= asr_pkg::BYTE_ZERO;
        end else if (ce_i && sample_i.valid) begin
          axis_q[g] <= trim_apply(raw, trim_q[g]);
        end
      end
      always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
          trim_q[g] <= asr_pkg::TRIM_RESET;
        end else if (ce_i && bus_req_i.wr) begin
          if (bus_req_i.addr == asr_pkg::ADDR_TRIM_BASE + 6'(2 * g)) begin
            trim_q[g][7:0] <= bus_req_i.wdata;
          end else if (bus_req_i.addr == asr_pkg::ADDR_TRIM_BASE + 6'(2 * g + 1)) begin
            trim_q[g][10:8] <= bus_req_i.wdata[2:0];
          end
        end
      end
    end
  endgenerate

  // A new sample always wins over a read that would clear the flags.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ready_q <= 1'b0;
      ovr_q   <= 1'b0;
    end else if (ce_i) begin
      if (sample_i.valid) begin
        ready_q <= 1'b1;
        ovr_q   <= ovr_q || ready_q;
      end else if (axis_read) begin
        ready_q <= 1'b0;
        ovr_q   <= 1'b0;
      end
    end
  end

  // Parity fault is sticky until reset; self-test stays blocked meanwhile.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      parity_q <= 1'b0;
    end else if (ce_i && trim_parity_err_i) begin
      parity_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      level_q <= 3'h0;
      pulse_q <= 3'h0;
    end else if (ce_i) begin
      level_q <= (clr1_level || clr2_level) ? detect_i.level_hit
                                            : (level_q | detect_i.level_hit);
      pulse_q <= (clr1_pulse || clr2_pulse) ? detect_i.pulse_hit
                                            : (pulse_q | detect_i.pulse_hit);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      irq1_q <= 1'b0;
      irq2_q <= 1'b0;
    end else if (ce_i) begin
      irq1_q <= irq1_evt || (irq1_q && !clr1);
      irq2_q <= irq2_evt || (irq2_q && !clr2);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      port_off_q <= asr_pkg::SLAVE_OFF_RESET;
    end else if (ce_i && bus_req_i.wr && (bus_req_i.addr == asr_pkg::ADDR_SLAVE)) begin
      port_off_q <= bus_req_i.wdata[asr_pkg::SLAVE_OFF_BIT];
    end
  end

  // One-time bytes are captured once after reset, so later OTP noise cannot alter them.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      user_q       <= asr_pkg::BYTE_ZERO;
      signature_q  <= asr_pkg::BYTE_ZERO;
      otp_loaded_q <= 1'b0;
    end else if (ce_i && otp_valid_i && !otp_loaded_q) begin
      user_q       <= otp_user_info_i;
      signature_q  <= otp_signature_i;
      otp_loaded_q <= 1'b1;
    end
  end

  assign det_byte = {level_q[0], level_q[1], level_q[2],
                     pulse_q[0], pulse_q[1], pulse_q[2], irq2_q, irq1_q};

  always_comb begin
    rd_data_d = asr_pkg::BYTE_ZERO;
    case (bus_req_i.addr)
      asr_pkg::ADDR_ACCEL_X:   rd_data_d = axis_q[0];
      asr_pkg::ADDR_ACCEL_Y:   rd_data_d = axis_q[1];
      asr_pkg::ADDR_ACCEL_Z:   rd_data_d = axis_q[2];
      asr_pkg::ADDR_STATUS:    rd_data_d = {5'h00, parity_q, ovr_q, ready_q};
      asr_pkg::ADDR_DETECT:    rd_data_d = det_byte;
      asr_pkg::ADDR_SLAVE:     rd_data_d = {port_off_q, asr_pkg::SLAVE_ADDR_RESET};
      asr_pkg::ADDR_USER:      rd_data_d = user_q;
      asr_pkg::ADDR_SIGNATURE: rd_data_d = signature_q;
      asr_pkg::ADDR_TRIM_BASE: rd_data_d = trim_q[0][7:0];
      asr_pkg::ADDR_TRIM_X_HI: rd_data_d = {5'h00, trim_q[0][10:8]};
      asr_pkg::ADDR_TRIM_Y_LO: rd_data_d = trim_q[1][7:0];
      asr_pkg::ADDR_TRIM_Y_HI: rd_data_d = {5'h00, trim_q[1][10:8]};
      asr_pkg::ADDR_TRIM_Z_LO: rd_data_d = trim_q[2][7:0];
      asr_pkg::ADDR_TRIM_LAST: rd_data_d = {5'h00, trim_q[2][10:8]};
      default:                 rd_data_d = asr_pkg::BYTE_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rd_data_o  <= asr_pkg::BYTE_ZERO;
      rd_valid_o <= 1'b0;
    end else if (ce_i) begin
      rd_valid_o <= bus_req_i.rd;
      if (bus_req_i.rd) begin
        rd_data_o <= rd_data_d;
      end
    end
  end

  // Pins are registered from the flags, so they trail the flags by one edge.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      irq_first_pin_o     <= 1'b0;
      irq_second_pin_o    <= 1'b0;
      two_wire_port_en_o  <= 1'b1;
      four_wire_port_en_o <= 1'b1;
      self_test_allow_o   <= 1'b1;
    end else if (ce_i) begin
      irq_first_pin_o     <= irq1_q || (ready_q && !ready_pin_mask_i);
      irq_second_pin_o    <= irq2_q;
      two_wire_port_en_o  <= !port_off_q;
      four_wire_port_en_o <= 1'b1;
      self_test_allow_o   <= !parity_q;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  a_ready_set: assert property (ce_i && sample_i.valid |=> ready_q)
    else $error("sample ready flag not set after new sample");
  a_ovr_set: assert property (ce_i && sample_i.valid && ready_q |=> ovr_q)
    else $error("overwrite flag not set on unread sample");
  a_read_clears: assert property (ce_i && axis_read && !sample_i.valid |=> !ready_q && !ovr_q)
    else $error("axis read did not clear ready flags");
  a_parity_set: assert property (ce_i && trim_parity_err_i |=> parity_q)
    else $error("parity fault not latched");
  a_parity_block: assert property (ce_i && parity_q |=> !self_test_allow_o)
    else $error("self-test not blocked after parity fault");
  a_irq1_level: assert property (ce_i && sel == asr_pkg::ASR_SEL_LEVEL_PULSE
                                 && level_any |=> irq1_q && (level_q != 3'h0))
    else $error("level event did not raise first flag");
  a_irq1_clear: assert property (ce_i && clr1 && !irq1_evt |=> !irq1_q)
    else $error("first flag not cleared by clear write");
  a_irq2_clear: assert property (ce_i && clr2 && !irq2_evt |=> !irq2_q)
    else $error("second flag not cleared by clear write");
  a_level_latch: assert property (ce_i |=> &(level_q | ~$past(detect_i.level_hit)))
    else $error("level hit not latched");
  a_pulse_latch: assert property (ce_i |=> &(pulse_q | ~$past(detect_i.pulse_hit)))
    else $error("pulse hit not latched");
  a_level_clear: assert property (ce_i && (clr1_level || clr2_level) && !level_any
                                  |=> level_q == 3'h0)
    else $error("level hits not cleared with their flag");
  a_sel_none: assert property (ce_i && sel == asr_pkg::ASR_SEL_UNUSED && !irq1_q |=> !irq1_q)
    else $error("first flag raised with no source selected");
  a_trim_write: assert property (
    ce_i && bus_req_i.wr && bus_req_i.addr == asr_pkg::ADDR_TRIM_BASE
    |=> trim_q[0][7:0] == $past(bus_req_i.wdata))
    else $error("low trim byte of first axis not written");
  a_otp_once: assert property (otp_loaded_q |=> $stable(signature_q))
    else $error("signature byte changed after load");
  a_pin_masked: assert property (ce_i && ready_pin_mask_i && !irq1_q |=> !irq_first_pin_o)
    else $error("masked ready reached first pin");
  a_addr_fixed: assert property (ce_i && is_read(bus_req_i, asr_pkg::ADDR_SLAVE)
                                 |=> rd_valid_o && rd_data_o[6:0] == asr_pkg::SLAVE_ADDR_RESET)
    else $error("slave address bits read wrong");
  a_status_zero: assert property (ce_i && is_read(bus_req_i, asr_pkg::ADDR_STATUS)
                                  |=> rd_data_o[7:3] == 5'h00)
    else $error("unused status bits not zero");
  a_pin_route: assert property (ce_i && ready_q && !ready_pin_mask_i |=> irq_first_pin_o)
    else $error("ready not routed to first pin");
  a_port_off: assert property (ce_i && port_off_q |=> !two_wire_port_en_o && four_wire_port_en_o)
    else $error("port enables wrong with two-wire off");

  c_overwrite: cover property (ce_i && sample_i.valid ##2 ce_i && sample_i.valid ##1 ovr_q);
  c_double_pulse: cover property (ce_i && detect_i.double_pulse && sel == asr_pkg::ASR_SEL_SINGLE_ANY);
  c_clear_race: cover property (ce_i && clr1 && irq1_evt);
  c_trim_read: cover property (ce_i && is_read(bus_req_i, asr_pkg::ADDR_TRIM_LAST));

endmodule // asr_regs

// [bench/asr_host_model.sv]
`timescale 1ns/1ps
// Host side of the register bank: bus accesses plus the control levels it owns.
module asr_host_model (
  input  wire logic             sys_clk_i,
  output asr_pkg::asr_bus_req_s bus_req_o,
  output logic                  ready_pin_mask_o,
  output logic [1:0]            irq_source_select_o
);
  initial begin
    bus_req_o = '0;
    ready_pin_mask_o = 1'b0;
    irq_source_select_o = 2'b00;
  end

  // One access per two cycles, so a request never merges with the next one.
  task automatic access(input logic wr, input logic [5:0] addr, input logic [7:0] data);
    @(negedge sys_clk_i);
    bus_req_o = {wr, ~wr, addr, data};
    @(negedge sys_clk_i);
    bus_req_o = '0;
  endtask

  task automatic set_mask(input logic m);
    @(negedge sys_clk_i);
    ready_pin_mask_o = m;
  endtask

  task automatic set_sel(input logic [1:0] s);
    @(negedge sys_clk_i);
    irq_source_select_o = s;
  endtask
endmodule // asr_host_model

// [bench/asr_regs_tb.sv]
`timescale 1ns/1ps
module asr_regs_tb;
  logic                  sys_clk_i = 1'b0;
  logic                  srst_i = 1'b1;
  logic                  ce_i = 1'b1;
  logic                  parity_err = 1'b0;
  logic                  otp_valid = 1'b0;
  logic [7:0]            otp_user = 8'h00;
  logic [7:0]            otp_sig = 8'h00;
  asr_pkg::asr_bus_req_s bus_req;
  asr_pkg::asr_sample_s  sample = '0;
  asr_pkg::asr_detect_s  detect = '0;
  logic [1:0]            sel;
  logic                  mask;
  logic [7:0]            rd_data;
  logic                  rd_valid, pin1, pin2, tw_en, fw_en, st_allow;
  int                    bad_count = 0;
  int                    num_checks = 0;
  int                    seed = 32'h192f9a16;
  logic [15:0]           exp_q[$];
  logic [10:0]           trim[3];
  logic [7:0]            x, y, z, eu, es, det, hi;
  logic [2:0]            l, p;

  always #5 sys_clk_i = ~sys_clk_i;

  asr_host_model host (.sys_clk_i(sys_clk_i), .bus_req_o(bus_req),
    .ready_pin_mask_o(mask), .irq_source_select_o(sel));

  asr_regs DUT (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(ce_i), .bus_req_i(bus_req),
    .sample_i(sample), .detect_i(detect), .irq_source_select_i(sel),
    .ready_pin_mask_i(mask), .trim_parity_err_i(parity_err), .otp_valid_i(otp_valid),
    .otp_user_info_i(otp_user), .otp_signature_i(otp_sig), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .irq_first_pin_o(pin1), .irq_second_pin_o(pin2),
    .two_wire_port_en_o(tw_en), .four_wire_port_en_o(fw_en), .self_test_allow_o(st_allow));

  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask

  // Each note holds the compare mask above the expected byte.
  always @(negedge sys_clk_i) begin
    logic [15:0] n;
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("Error rd_data_o expected none seen %h", rd_data);
      end else begin
        n = exp_q.pop_front();
        chk_byte("rd_data_o", n[7:0], rd_data & n[15:8]);
      end
    end
  end

  task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    exp_q.push_back({m, e & m});
    host.access(1'b0, a, 8'h00);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host.access(1'b1, a, d);
  endtask

  function automatic logic [7:0] rnd8();
    int r;
    r = $random(seed);
    return r[7:0];
  endfunction

  // Floor of the half-count sum, clamped to the signed byte range.
  function automatic logic [7:0] corr(input logic [7:0] raw, input logic [10:0] t);
    int v;
    v = ($signed(raw) * 2 + $signed(t)) >>> 1;
    if (v > 127) v = 127;
    if (v < -128) v = -128;
    return v[7:0];
  endfunction

  task automatic pulse_sample();
    @(negedge sys_clk_i);
    sample = {1'b1, x, y, z};
    @(negedge sys_clk_i);
    sample.valid = 1'b0;
  endtask

  task automatic pulse_detect(input logic [2:0] lv, input logic [2:0] pv, input logic dp);
    @(negedge sys_clk_i);
    detect = {lv, pv, dp};
    @(negedge sys_clk_i);
    detect = '0;
    @(negedge sys_clk_i);
  endtask

  task automatic tally_and_finish();
    if (exp_q.size() != 0) bad_count++;
    if (bad_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #100us;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(negedge sys_clk_i);
    srst_i = 1'b0;
    for (int a = 0; a < 24; a++) rd(a[5:0], (a == 13) ? 8'h1d : 8'h00);
    chk_bit("two_wire_port_en_o", 1'b1, tw_en);
    chk_bit("self_test_allow_o", 1'b1, st_allow);
    eu = rnd8();
    es = rnd8();
    otp_user = eu;
    otp_sig = es;
    @(negedge sys_clk_i);
    otp_valid = 1'b1;
    @(negedge sys_clk_i);
    otp_user = ~eu;
    otp_sig = ~es;
    wr(6'h0e, ~eu);
    wr(6'h0f, ~es);
    rd(6'h0e, eu);
    rd(6'h0f, es);
    wr(6'h0d, 8'hff);
    rd(6'h0d, 8'h9d);
    chk_bit("two_wire_port_en_o", 1'b0, tw_en);
    chk_bit("four_wire_port_en_o", 1'b1, fw_en);
    wr(6'h0d, 8'h00);
    @(negedge sys_clk_i);
    chk_bit("two_wire_port_en_o", 1'b1, tw_en);
    for (int i = 0; i < 3; i++) begin
      hi = rnd8();
      trim[i] = {hi[2:0], rnd8()};
      wr(6'h10 + 6'(2 * i), trim[i][7:0]);
      wr(6'h11 + 6'(2 * i), {5'b10101, trim[i][10:8]});
      rd(6'h10 + 6'(2 * i), trim[i][7:0]);
      rd(6'h11 + 6'(2 * i), {5'h00, trim[i][10:8]});
    end
    // A frozen cycle must not take a write.
    @(negedge sys_clk_i);
    ce_i = 1'b0;
    wr(6'h10, ~trim[0][7:0]);
    ce_i = 1'b1;
    rd(6'h10, trim[0][7:0]);
    host.set_mask(1'b0);
    for (int k = 0; k < 2; k++) begin
      x = rnd8();
      y = rnd8();
      z = rnd8();
      pulse_sample();
    end
    @(negedge sys_clk_i);
    chk_bit("irq_first_pin_o", 1'b1, pin1);
    rd(6'h09, 8'h03);
    rd(6'h06, corr(x, trim[0]));
    rd(6'h07, corr(y, trim[1]));
    rd(6'h08, corr(z, trim[2]));
    rd(6'h09, 8'h00);
    chk_bit("irq_first_pin_o", 1'b0, pin1);
    host.set_mask(1'b1);
    pulse_sample();
    @(negedge sys_clk_i);
    chk_bit("irq_first_pin_o", 1'b0, pin1);
    rd(6'h09, 8'h01);
    rd(6'h08, corr(z, trim[2]));
    for (int s = 0; s < 3; s++) begin
      host.set_sel(s[1:0]);
      hi = rnd8() | 8'h01;
      l = (s == 2) ? 3'b000 : hi[2:0];
      hi = rnd8() | 8'h01;
      p = hi[2:0];
      pulse_detect(l, p, 1'b0);
      chk_bit("irq_first_pin_o", 1'b1, pin1);
      chk_bit("irq_second_pin_o", 1'b1, pin2);
      det = {l[0], l[1], l[2], p[0], p[1], p[2], 2'b11};
      rd(6'h0a, det);
      wr(6'h17, 8'h01);
      if (s == 0) det[7:5] = 3'b000;
      else det[4:2] = 3'b000;
      det[0] = 1'b0;
      rd(6'h0a, det);
      wr(6'h17, 8'h02);
      if (s == 1) det[7:5] = 3'b000;
      else det[4:2] = 3'b000;
      det[1] = 1'b0;
      rd(6'h0a, det);
      chk_bit("irq_first_pin_o", 1'b0, pin1);
      chk_bit("irq_second_pin_o", 1'b0, pin2);
    end
    // Pulse hits carry no meaning on a double pulse, so only the flags are judged.
    pulse_detect(3'b000, 3'b000, 1'b1);
    rd(6'h0a, 8'h02, 8'h03);
    wr(6'h17, 8'h03);
    host.set_sel(2'b11);
    pulse_detect(3'b111, 3'b111, 1'b1);
    rd(6'h0a, 8'h00, 8'h03);
    @(negedge sys_clk_i);
    parity_err = 1'b1;
    @(negedge sys_clk_i);
    parity_err = 1'b0;
    @(negedge sys_clk_i);
    chk_bit("self_test_allow_o", 1'b0, st_allow);
    rd(6'h09, 8'h04, 8'hfc);
    repeat (4) @(negedge sys_clk_i);
    tally_and_finish();
  end
endmodule // asr_regs_tb
